// ===== verilog/rcac_pkg.sv
//==============================================================================
// Reset, power-on sequencing and slow-clock configuration: shared definitions
//==============================================================================
// Purpose: Constants, field layouts, reset values and carrier types of the block.
// Assumes: Block clock is the internal RC clock at 100 MHz.
// Notes:   Contract

package rcac_pkg;

  //============================================================================
  // Timing
  //============================================================================
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned RESET_EXIT_NS    = 1400;
  localparam int unsigned RESET_EXIT_CYC   = RESET_EXIT_NS * CLK_MHZ / 1000;
  localparam int unsigned IRQ_SET_US       = 100;
  localparam int unsigned IRQ_SET_CYC      = IRQ_SET_US * CLK_MHZ;
  localparam int unsigned IRQ_CLR_US       = 90;
  localparam int unsigned IRQ_CLR_CYC      = IRQ_CLR_US * CLK_MHZ;
  localparam int unsigned IRQ_CNT_W        = 14;
  localparam int unsigned RC_DIV_W         = 6;      // Divide by 64
  localparam logic [7:0]  POR_PRESET       = 8'hFF;

  //============================================================================
  // Slow-clock setup register
  //============================================================================
  localparam int unsigned CLK_OUT_EN_BIT   = 6;
  localparam int unsigned BYPASS_BIT       = 3;
  localparam int unsigned SRC_LSB          = 0;
  localparam logic [7:0]  CLK_SETUP_MASK   = 8'h4B;
  localparam logic [7:0]  CLK_SETUP_RESET  = 8'h00;
  localparam logic [1:0]  SRC_RC_DIV       = 2'b00;
  localparam logic [1:0]  SRC_EXTERNAL     = 2'b11;

  //============================================================================
  // Configuration defaults and address
  //============================================================================
  localparam logic [3:0]  KEY_ROWS_DEF     = 4'h3;
  localparam logic [3:0]  KEY_COLS_DEF     = 4'h3;
  localparam logic [7:0]  DEBOUNCE_DEF     = 8'h03;
  localparam logic [7:0]  ACTIVE_TIME_DEF  = 8'h7D;  // 125 units of 4 ms
  localparam logic [6:0]  ADDR_BASE        = 7'h42;
  localparam int unsigned ROW8_BIT         = 8;

  //============================================================================
  // Types
  //============================================================================
  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_WAIT_IRQ = 3'b001,
    ST_WAIT_CFG = 3'b011,
    ST_CFG_DLY  = 3'b010,
    ST_RUN      = 3'b110
  } rcac_state_e;

  typedef struct packed {
    logic [3:0] key_rows;
    logic [3:0] key_cols;
    logic       mux_enable;
    logic       irq_enable;
    logic       irq_active_low;
    logic [7:0] debounce;
    logic [7:0] active_time;
  } rcac_dev_cfg_s;

  typedef struct packed {
    logic [7:0]  col_pullup;
    logic [11:0] row_oe;
    logic [11:0] row_out;
    logic        irq_n_out;
    logic        irq_n_oe;
    logic [2:0]  pwm_oe;
    logic [1:0]  addr_pin_oe;
    logic        bus_open_drain;
    logic        crystal_out_pullup;
  } rcac_pins_s;

endpackage

// ===== verilog/rcac_sync3.sv
//==============================================================================
// Three-stage pin synchroniser with agreement filter
//==============================================================================
// Purpose: Brings asynchronous pins onto the block clock.
// Assumes: Each bit is an independent level.
// Notes:   A bit changes only once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module rcac_sync3 #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         ce,
  // Levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } rcac_sync_s;

  rcac_sync_s q;
  rcac_sync_s d;

  always_comb
  begin
    d     = q;
    d.s1  = pin_in;
    d.s2  = q.s1;
    d.s3  = q.s2;
    for (int i = 0; i < int'(W); i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.lvl[i] = q.s3[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    else if (ce)
      q <= d;
  end

  assign level_out = q.lvl;

endmodule // rcac_sync3

`default_nettype wire

// ===== verilog/rcac_por_timer.sv
//==============================================================================
// Power-on reset down-counter
//==============================================================================
// Purpose: Holds the power-on reset for 256 RC cycles after supply is good.
// Assumes: supply_ok is already synchronised.
// Notes:   A supply dip re-arms the counter.
`timescale 1ns/10ps
`default_nettype none

module rcac_por_timer
  import rcac_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic ce,
  // Supply and reset
  input  wire logic supply_ok,
  output logic      por_active
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       active;
  } rcac_por_s;

  rcac_por_s q;
  rcac_por_s d;

  always_comb
  begin
    d = q;
    if (!supply_ok)
    begin
      d.cnt    = POR_PRESET;
      d.active = 1'b1;
    end
    else if (q.active)
    begin
      d.cnt = q.cnt - 8'h01;
      if (q.cnt == 8'h00)
        d.active = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      q <= {POR_PRESET, 1'b1};
    else if (ce)
      q <= d;
  end

  assign por_active = q.active;

  default clocking por_cb @(posedge clock); endclocking
  default disable iff (!resetn || !ce);

  por_preset_a: assert property (!supply_ok |=> q.cnt == POR_PRESET && por_active)
    else $error("power-on counter not preset while supply low");
  por_release_a: assert property (supply_ok && q.active && q.cnt == 8'h00 |=> !por_active)
    else $error("power-on reset not released on underflow");

endmodule // rcac_por_timer

`default_nettype wire

// ===== verilog/rcac_core.sv
//==============================================================================
// Reset, power-on sequencing and slow-clock configuration
//==============================================================================
// Purpose: Combines reset sources, applies defaults, drives pin states, holds the
//          slow-clock setup byte and the sampled slave address.
// Assumes: Host command decode delivers one-cycle strobes on this clock.
// Notes:   Pin reset acts after the three-stage synchroniser, well inside 1400 ns.
`timescale 1ns/10ps
`default_nettype none

module rcac_core
  import rcac_pkg::*;
#(
  parameter int unsigned IRQ_SET_CYC_P = IRQ_SET_CYC,
  parameter int unsigned IRQ_CLR_CYC_P = IRQ_CLR_CYC
) (
  // Clock, reset and enable
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  // Asynchronous pins
  input  wire logic                   reset_pin_n,
  input  wire logic                   supply_ok,
  input  wire logic                   low_freq_clock_in,
  input  wire logic [1:0]             addr_select_pins,
  // Host commands
  input  wire logic                   reset_cmd,
  input  wire logic                   config_cmd,
  input  wire logic                   clk_setup_we,
  input  wire logic [7:0]             clk_setup_wdata,
  // First bus byte
  input  wire logic                   addr_byte_valid,
  input  wire logic [7:0]             addr_byte,
  // Clock configuration
  output logic [7:0]                  slow_clock_setup,
  output logic                        slow_clock_out_enable,
  output logic                        crystal_bypass_select,
  output logic [1:0]                  pwm_clock_source,
  output logic                        crystal_osc_enable,
  output logic                        pwm_timebase,
  // Device state
  output var rcac_pkg::rcac_dev_cfg_s dev_cfg,
  output var rcac_pkg::rcac_pins_s    pins,
  output logic                        in_reset,
  output logic                        uninitialized_flag,
  output logic [6:0]                  slave_address,
  output logic                        addr_hit,
  output logic                        addr_read
);

  //============================================================================
  // State
  //============================================================================
  typedef struct packed {
    rcac_state_e          st;
    logic                 in_reset;
    logic                 uninit;
    logic [IRQ_CNT_W-1:0] cnt;
    logic [RC_DIV_W-1:0]  div;
    logic                 timebase;
    logic [7:0]           setup;
    logic                 xtal_en;
    rcac_dev_cfg_s        dev;
    logic [6:0]           addr;
    logic                 addr_hit;
    logic                 addr_read;
    rcac_pins_s           pins;
  } rcac_core_s;

  localparam logic [IRQ_CNT_W-1:0] SET_LAST = IRQ_CNT_W'(IRQ_SET_CYC_P - 1);
  localparam logic [IRQ_CNT_W-1:0] CLR_LAST = IRQ_CNT_W'(IRQ_CLR_CYC_P - 1);
  localparam int REL_MAX = RESET_EXIT_CYC;

  rcac_core_s q;
  rcac_core_s d;

  logic [4:0] pin_lvl;
  logic       rst_n_s;
  logic       supply_s;
  logic [1:0] addr_s;
  logic       lfclk_s;
  logic       por_active;
  logic       rst_req;

  //============================================================================
  // Pin synchronisers and power-on timer
  //============================================================================
  rcac_sync3 #(
    .W       (5),
    .RST_VAL (5'h01)
  ) u_sync (
    .clock     (clock),
    .resetn    (resetn),
    .ce        (ce),
    .pin_in    ({low_freq_clock_in, addr_select_pins, supply_ok, reset_pin_n}),
    .level_out (pin_lvl)
  );

  assign rst_n_s  = pin_lvl[0];
  assign supply_s = pin_lvl[1];
  assign addr_s   = pin_lvl[3:2];
  assign lfclk_s  = pin_lvl[4];

  rcac_por_timer u_por (
    .clock      (clock),
    .resetn     (resetn),
    .ce         (ce),
    .supply_ok  (supply_s),
    .por_active (por_active)
  );

  // Any of the three sources; the registered copy releases everything together
  assign rst_req = !rst_n_s || por_active || reset_cmd;

  //============================================================================
  // Next state
  //============================================================================
  always_comb
  begin
    d          = q;
    d.in_reset = rst_req;
    d.addr_hit = 1'b0;
    d.div      = q.div + RC_DIV_W'(1);
    // Timebase follows the selected source; reserved codes park it low
    unique case (q.setup[SRC_LSB +: 2])
      SRC_RC_DIV:   d.timebase = q.div[RC_DIV_W-1];
      SRC_EXTERNAL: d.timebase = lfclk_s;
      default:      d.timebase = 1'b0;
    endcase
    d.xtal_en = !q.setup[BYPASS_BIT];

    if (q.in_reset)
    begin
      d.st                      = ST_RESET;
      d.cnt                     = '0;
      d.uninit                  = 1'b1;
      d.setup                   = CLK_SETUP_RESET;
      d.dev.key_rows            = KEY_ROWS_DEF;
      d.dev.key_cols            = KEY_COLS_DEF;
      d.dev.mux_enable          = 1'b0;
      d.dev.irq_enable          = 1'b1;
      d.dev.irq_active_low      = 1'b1;
      d.dev.debounce            = DEBOUNCE_DEF;
      d.dev.active_time         = ACTIVE_TIME_DEF;
      d.addr                    = ADDR_BASE + {5'h00, addr_s};
      d.addr_read               = 1'b0;
      // Everything floats; bus pins stay open-drain, crystal output weakly up
      d.pins                    = '0;
      d.pins.bus_open_drain     = 1'b1;
      d.pins.crystal_out_pullup = 1'b1;
    end
    else
    begin
      unique case (q.st)
        ST_RESET:
        begin
          d.st                  = ST_WAIT_IRQ;
          d.pins.col_pullup     = 8'h0F;
          d.pins.row_oe         = 12'h007;
          d.pins.row_out        = 12'h000;
        end
        ST_WAIT_IRQ:
        begin
          d.cnt = q.cnt + IRQ_CNT_W'(1);
          if (q.cnt == SET_LAST)
          begin
            d.st             = ST_WAIT_CFG;
            d.cnt            = '0;
            d.pins.irq_n_oe  = 1'b1;
            d.pins.irq_n_out = 1'b0;
          end
        end
        ST_WAIT_CFG:
        begin
          if (config_cmd)
          begin
            d.st     = ST_CFG_DLY;
            d.uninit = 1'b0;
          end
        end
        ST_CFG_DLY:
        begin
          d.cnt = q.cnt + IRQ_CNT_W'(1);
          if (q.cnt == CLR_LAST)
          begin
            d.st             = ST_RUN;
            d.cnt            = '0;
            d.pins.irq_n_out = 1'b1;
          end
        end
        ST_RUN:
        begin
          d.st = ST_RUN;
        end
        default:
        begin
          d.st = ST_RESET;
        end
      endcase

      // Written once at init by the host; later writes are still taken
      if (clk_setup_we)
        d.setup = clk_setup_wdata & CLK_SETUP_MASK;

      // Shared row-8 pin follows the new setup byte, so the pin is released
      // in the same cycle that the buffer enable drops
      if (d.setup[CLK_OUT_EN_BIT])
      begin
        d.pins.row_oe[ROW8_BIT]  = 1'b1;
        d.pins.row_out[ROW8_BIT] = q.timebase;
      end
      else
      begin
        d.pins.row_oe[ROW8_BIT]  = 1'b0;
        d.pins.row_out[ROW8_BIT] = 1'b0;
      end

      if (addr_byte_valid)
      begin
        d.addr_hit  = (addr_byte[7:1] == q.addr);
        d.addr_read = addr_byte[0];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      q          <= '0;
      q.in_reset <= 1'b1;
      q.uninit   <= 1'b1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  //============================================================================
  // Outputs
  //============================================================================
  assign slow_clock_setup      = q.setup;
  assign slow_clock_out_enable = q.setup[CLK_OUT_EN_BIT];
  assign crystal_bypass_select = q.setup[BYPASS_BIT];
  assign pwm_clock_source      = q.setup[SRC_LSB +: 2];
  assign crystal_osc_enable    = q.xtal_en;
  assign pwm_timebase          = q.timebase;
  assign dev_cfg               = q.dev;
  assign pins                  = q.pins;
  assign in_reset              = q.in_reset;
  assign uninitialized_flag    = q.uninit;
  assign slave_address         = q.addr;
  assign addr_hit              = q.addr_hit;
  assign addr_read             = q.addr_read;

  //============================================================================
  // Checks
  //============================================================================
  default clocking core_cb @(posedge clock); endclocking
  default disable iff (!resetn || !ce);

  sequence s_cfg_taken;
    q.st == ST_WAIT_CFG && config_cmd && !q.in_reset;
  endsequence

  sequence s_cfg_applied;
    q.st == ST_CFG_DLY && !uninitialized_flag && !pins.irq_n_out;
  endsequence

  pin_reset_a: assert property (!rst_n_s |=> in_reset)
    else $error("reset pin low did not enter reset");
  cmd_reset_a: assert property (reset_cmd |=> in_reset)
    else $error("reset command did not enter reset");
  sync_release_a: assert property (!rst_req |=> !in_reset)
    else $error("reset not released on the next edge");
  pin_exit_a: assert property ($rose(reset_pin_n) && supply_s && !por_active && !reset_cmd
    ##1 (!reset_cmd && reset_pin_n)[*4] |-> ##[0:REL_MAX] !in_reset)
    else $error("reset pin release too slow");
  reset_float_a: assert property (in_reset |=> pins.row_oe == 12'h000 && !pins.irq_n_oe
    && pins.col_pullup == 8'h00 && pins.bus_open_drain && pins.crystal_out_pullup)
    else $error("pins not floating in reset");
  init_pins_a: assert property (in_reset ##1 !in_reset |=> pins.col_pullup == 8'h0F
    && pins.row_oe[2:0] == 3'h7 && pins.row_out[2:0] == 3'h0)
    else $error("initial pin states wrong");
  spare_pins_a: assert property (!in_reset && !slow_clock_out_enable
    |-> pins.col_pullup[7:4] == 4'h0 && pins.row_oe[11:3] == 9'h000)
    else $error("unconfigured scan pins driven");
  defaults_a: assert property (in_reset |=> dev_cfg.key_rows == KEY_ROWS_DEF
    && dev_cfg.mux_enable == 1'b0 && dev_cfg.irq_active_low && uninitialized_flag
    && pwm_clock_source == SRC_RC_DIV)
    else $error("reset defaults wrong");
  timing_def_a: assert property (in_reset |=> dev_cfg.debounce == DEBOUNCE_DEF
    && dev_cfg.active_time == ACTIVE_TIME_DEF)
    else $error("debounce or active time default wrong");
  setup_mask_a: assert property (clk_setup_we && !in_reset && !rst_req
    |=> slow_clock_setup == ($past(clk_setup_wdata) & CLK_SETUP_MASK))
    else $error("setup byte not stored with reserved bits clear");
  xtal_sel_a: assert property (!in_reset |=> crystal_osc_enable
    == !$past(crystal_bypass_select))
    else $error("crystal oscillator enable wrong");
  src_rc_a: assert property (!in_reset && pwm_clock_source == SRC_RC_DIV
    |=> pwm_timebase == $past(q.div[RC_DIV_W-1]))
    else $error("timebase not RC divided by 64");
  row8_clk_a: assert property (!in_reset && !rst_req && slow_clock_out_enable && !clk_setup_we
    |=> pins.row_oe[ROW8_BIT] && pins.row_out[ROW8_BIT] == $past(pwm_timebase))
    else $error("row-8 pin not carrying slow clock");
  addr_pick_a: assert property (in_reset |=> slave_address
    == ADDR_BASE + {5'h00, $past(addr_s)})
    else $error("slave address not from sampled pins");
  addr_match_a: assert property (addr_byte_valid && !in_reset |=> addr_hit
    == ($past(addr_byte[7:1]) == slave_address) && addr_read == $past(addr_byte[0]))
    else $error("address byte compare wrong");
  irq_set_a: assert property ($rose(pins.irq_n_oe) |-> $past(q.cnt) == SET_LAST
    && $past(q.st) == ST_WAIT_IRQ && !pins.irq_n_out)
    else $error("interrupt asserted at wrong time");
  irq_clr_a: assert property (!in_reset && $rose(pins.irq_n_out)
    |-> $past(q.cnt) == CLR_LAST && $past(q.st) == ST_CFG_DLY)
    else $error("interrupt released at wrong time");
  cfg_take_a: assert property (s_cfg_taken and !rst_req |=> s_cfg_applied)
    else $error("configuration command not taken");

endmodule // rcac_core

`default_nettype wire

// ===== sim/rcac_host_model.sv
//==============================================================================
// Host and board model
//==============================================================================
// Purpose: Drives host command strobes and the board-level pins of the block.
// Assumes: Callers sit 1 ns after a rising clock edge.
// Notes:   Data lines show the inverse once a strobe drops, never a stale value.
`timescale 1ns/10ps
`default_nettype none

module rcac_host_model (
  // Clock
  input  wire logic  clock,
  // Board pins
  output logic       reset_pin_n,
  output logic       supply_ok,
  output logic [1:0] addr_select_pins,
  // Host commands
  output logic       config_cmd,
  output logic       clk_setup_we,
  output logic [7:0] clk_setup_wdata,
  output logic       addr_byte_valid,
  output logic [7:0] addr_byte
);
  initial
  begin
    {config_cmd, clk_setup_we, addr_byte_valid, supply_ok} = '0;
    {clk_setup_wdata, addr_byte} = '0;
    reset_pin_n = 1'b1;
    addr_select_pins = 2'b10;
  end

  // Address pins only move together with the reset pin level
  task automatic board(input logic pin_n, sup, input logic [1:0] sel);
    reset_pin_n = pin_n;
    supply_ok = sup;
    addr_select_pins = sel;
  endtask

  // Kind 0 configuration, 1 setup byte (once in a real system), 2 first bus byte
  task automatic cmd(input logic [1:0] kind, input logic [7:0] data);
    @(posedge clock);
    #1;
    clk_setup_wdata = data;
    addr_byte = data;
    config_cmd = (kind == 2'd0);
    clk_setup_we = (kind == 2'd1);
    addr_byte_valid = (kind == 2'd2);
    @(posedge clock);
    #1;
    {config_cmd, clk_setup_we, addr_byte_valid} = '0;
    {clk_setup_wdata, addr_byte} = {~data, ~data};
  endtask
endmodule // rcac_host_model

`default_nettype wire

// ===== sim/reset_clock_addr_config_tb_top.sv
//==============================================================================
// Testbench top
//==============================================================================
// Purpose: Runs reset, setup byte and address scenarios against the core.
// Assumes: Short interrupt counts of 20 and 15 cycles.
// Notes:   All inputs move 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module reset_clock_addr_config_tb_top;
  import rcac_pkg::*;
  logic clock, resetn, ce, reset_cmd, reset_pin_n, supply_ok, low_freq_clock_in;
  logic config_cmd, clk_setup_we, addr_byte_valid, in_reset, uninitialized_flag;
  logic slow_clock_out_enable, crystal_bypass_select, crystal_osc_enable, pwm_timebase;
  logic addr_hit, addr_read;
  logic [1:0] addr_select_pins, pwm_clock_source;
  logic [7:0] clk_setup_wdata, addr_byte, slow_clock_setup;
  logic [6:0] slave_address;
  rcac_dev_cfg_s dev_cfg;
  rcac_pins_s pins;
  logic [7:0] tbl [4] = '{8'hFF, 8'h08, 8'h01, 8'h02};
  logic [7:0] abt [3] = '{8'h89, 8'h88, 8'h87};
  int err_total, check_count, n;

  rcac_host_model host (.clock, .reset_pin_n, .supply_ok, .addr_select_pins, .config_cmd,
    .clk_setup_we, .clk_setup_wdata, .addr_byte_valid, .addr_byte);
  rcac_core #(.IRQ_SET_CYC_P(20), .IRQ_CLR_CYC_P(15)) dut (.clock, .resetn, .ce,
    .reset_pin_n, .supply_ok, .low_freq_clock_in, .addr_select_pins, .reset_cmd,
    .config_cmd, .clk_setup_we, .clk_setup_wdata, .addr_byte_valid, .addr_byte,
    .slow_clock_setup, .slow_clock_out_enable, .crystal_bypass_select, .pwm_clock_source,
    .crystal_osc_enable, .pwm_timebase, .dev_cfg, .pins, .in_reset, .uninitialized_flag,
    .slave_address, .addr_hit, .addr_read);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Selector 0 in_reset, 1 interrupt enable, 2 interrupt level
  task automatic wait_on(input int sel, input logic lvl, input int lim, output int k);
    k = 0;
    while ((sel == 0 ? in_reset : sel == 1 ? pins.irq_n_oe : pins.irq_n_out) !== lvl)
    begin
      cyc(1);
      k++;
      if (k > lim)
      begin
        err_total++;
        $display("unexpected wait %0d expected %b seen timeout", sel, lvl);
        complete_run();
      end
    end
  endtask

  initial
  begin
    {resetn, reset_cmd, low_freq_clock_in} = '0;
    ce = 1'b1;
    cyc(5);
    resetn = 1'b1;
    host.board(1'b1, 1'b1, 2'b10);
    wait_on(0, 1'b0, 400, n);
    // Initial pin states land one edge after the internal reset drops
    cyc(1);
    chk("por_cycles", n >= 256 && n <= 300, 1'b1);
    chk("dev_cfg", dev_cfg, {8'h33, 3'b011, 8'h03, ACTIVE_TIME_DEF});
    chk("pins_init", {pins.col_pullup, pins.row_oe, pins.pwm_oe, pins.addr_pin_oe,
      pins.bus_open_drain, pins.crystal_out_pullup}, {8'h0F, 12'h007, 5'h00, 2'b11});
    chk("row_out", pins.row_out[2:0], 3'b000);
    chk("slave_address", slave_address, 7'h44);
    chk("pwm_clock_source", pwm_clock_source, 2'b00);
    host.cmd(2'd0, 8'h00);
    chk("early_cfg", uninitialized_flag, 1'b1);
    wait_on(1, 1'b1, 40, n);
    chk("irq_set", {n >= 18 && n <= 22, pins.irq_n_out}, 2'b10);
    host.cmd(2'd0, 8'h00);
    cyc(1);
    chk("uninitialized_flag", uninitialized_flag, 1'b0);
    wait_on(2, 1'b1, 30, n);
    chk("irq_clr", n >= 12 && n <= 17, 1'b1);
    foreach (tbl[i])
    begin
      host.cmd(2'd1, tbl[i]);
      chk("slow_clock_setup", slow_clock_setup, tbl[i] & 8'h4B);
      cyc(2);
      chk("pwm_clock_source", pwm_clock_source, tbl[i][1:0]);
      chk("crystal_osc_enable", crystal_osc_enable, !tbl[i][3]);
      chk("row8", {pins.row_oe[8], slow_clock_out_enable}, {2{tbl[i][6]}});
      if (tbl[i][1] ^ tbl[i][0])
        chk("pwm_timebase", pwm_timebase, 1'b0);
    end
    foreach (abt[i])
    begin
      host.cmd(2'd2, abt[i]);
      chk("addr_hit", addr_hit, abt[i][7:1] == 7'h44);
      if (abt[i][7:1] == 7'h44)
        chk("addr_read", addr_read, abt[i][0]);
    end
    host.board(1'b0, 1'b1, 2'b01);
    wait_on(0, 1'b1, 8, n);
    cyc(1);
    chk("pins_reset", {pins.row_oe, pins.col_pullup, pins.irq_n_oe, pins.pwm_oe}, '0);
    cyc(72);
    host.board(1'b1, 1'b1, 2'b01);
    wait_on(0, 1'b0, 140, n);
    chk("slave_address", slave_address, 7'h43);
    reset_cmd = 1'b1;
    cyc(1);
    reset_cmd = 1'b0;
    chk("in_reset_cmd", in_reset, 1'b1);
    wait_on(0, 1'b0, 20, n);
    complete_run();
  end
endmodule // reset_clock_addr_config_tb_top

`default_nettype wire
